// File: mrs_pkg.sv
// Purpose: Shared constants and types of the RTU slave framer.
// Assumes: 250 MHz system clock, register port with 8-bit byte addresses.
// Notes:   Character timing is derived from a clocks-per-bit divisor.
package mrs_pkg;

  // ************************************************************
  // Clock and default line rate
  // ************************************************************
  localparam int SYS_CLK_HZ = 250_000_000;
  localparam int BAUD_DEF   = 9600;
  localparam logic [15:0] BAUD_DIV_RST =
    16'((SYS_CLK_HZ + BAUD_DEF / 2) / BAUD_DEF);

  // ************************************************************
  // Register offsets
  // ************************************************************
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_BAUD   = 8'h04;
  localparam logic [7:0] REG_STAT   = 8'h08;
  localparam logic [7:0] REG_TXDATA = 8'h10;
  localparam logic [7:0] REG_TXCTRL = 8'h14;
  localparam logic [7:0] REG_RXBUF  = 8'h80;

  // ************************************************************
  // Field positions and reset values
  // ************************************************************
  localparam int CTRL_DATA8   = 0;
  localparam int CTRL_PAR_LO  = 1;
  localparam int CTRL_ADDR_LO = 8;
  localparam logic [15:0] CTRL_RST = 16'h0101;
  localparam int ST_READY = 0;
  localparam int ST_CRC   = 1;
  localparam int ST_PAR   = 2;
  localparam int ST_LEN   = 3;
  localparam int ST_BCAST = 4;
  localparam int ST_FRD   = 5;
  localparam int ST_FWR   = 6;
  localparam int ST_FOTH  = 7;
  localparam int ST_BUSY  = 8;
  localparam int ST_LEN_LO = 16;
  localparam int TXC_GO    = 0;
  localparam int TXC_CLR   = 1;

  // ************************************************************
  // Protocol figures
  // ************************************************************
  localparam logic [1:0]  PAR_NONE = 2'h0;
  localparam logic [1:0]  PAR_EVEN = 2'h1;
  localparam logic [1:0]  PAR_ODD  = 2'h2;
  localparam logic [7:0]  CHAR_BITS_8 = 8'h0b;
  localparam logic [7:0]  CHAR_BITS_7 = 8'h0a;
  localparam logic [7:0]  GAP15_HB = 8'h03;
  localparam logic [7:0]  GAP35_HB = 8'h07;
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'ha001;
  localparam logic [7:0]  FUNC_READ  = 8'h03;
  localparam logic [7:0]  FUNC_WRITE = 8'h06;
  localparam logic [7:0]  ADDR_BCAST = 8'h00;
  localparam logic [5:0]  MIN_FRAME  = 6'h06;
  localparam logic [15:0] MAX_READ_WORDS = 16'h0010;
  localparam int          BUF_DEPTH  = 32;
  localparam logic [5:0]  BUF_FULL   = 6'h20;

  // ************************************************************
  // State types
  // ************************************************************
  typedef enum logic [1:0] {
    FR_WAIT  = 2'b00,
    FR_READY = 2'b01,
    FR_BODY  = 2'b11
  } mrs_fr_st_t;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_WAIT = 2'b01,
    TX_SEND = 2'b11
  } mrs_tx_st_t;

endpackage

// File: mrs_framer.sv
// Purpose: Slave-side RTU framer for a half-duplex RS485 port.
// Assumes: i_rxd is synchronous to i_clk_sys; baud divisor of 4 or more.
// Notes:   Payload handling is left to software via the buffers.
`timescale 1ns/1ps
module mrs_framer
  import mrs_pkg::*;
(
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst,
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  input  wire logic        i_rxd,
  output logic             o_txd,
  output logic             o_de
);

  // ************************************************************
  // Functions
  // ************************************************************
  function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                           input logic [7:0]  b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      if (r[0]) begin
        r = (r >> 1) ^ CRC_POLY;
      end else begin
        r = r >> 1;
      end
    end
    return r;
  endfunction

  function automatic logic [7:0] char_bits(input logic d8);
    return d8 ? CHAR_BITS_8 : CHAR_BITS_7;
  endfunction

  // Whole character, bit 0 first on the line; unused top bit is idle
  function automatic logic [10:0] char_frame(input logic [7:0] b,
                                             input logic       d8,
                                             input logic [1:0] par);
    logic p;
    p = (d8 ? ^b : ^b[6:0]) ^ (par == PAR_ODD);
    if (par == PAR_NONE) begin
      p = 1'b1;
    end
    if (d8) begin
      return {1'b1, p, b, 1'b0};
    end else begin
      return {2'b11, p, b[6:0], 1'b0};
    end
  endfunction

  // ************************************************************
  // Configuration
  // ************************************************************
  logic [15:0] ctrl;
  logic [15:0] baud_div;
  logic        cfg_d8;
  logic [1:0]  cfg_par;
  logic [7:0]  cfg_addr;
  logic [7:0]  nbits;
  logic [7:0]  t15;
  logic [7:0]  t35;

  assign cfg_d8   = ctrl[CTRL_DATA8];
  assign cfg_par  = ctrl[CTRL_PAR_LO +: 2];
  assign cfg_addr = ctrl[CTRL_ADDR_LO +: 8];
  assign nbits    = char_bits(cfg_d8);
  assign t15      = GAP15_HB * nbits;
  assign t35      = GAP35_HB * nbits;

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      ctrl     <= CTRL_RST;
      baud_div <= BAUD_DIV_RST;
    end else if (i_wr && i_addr == REG_CTRL) begin
      ctrl     <= i_wdata[15:0];
    end else if (i_wr && i_addr == REG_BAUD) begin
      baud_div <= i_wdata[15:0];
    end
  end

  // ************************************************************
  // Line idle timer in half-bit units
  // ************************************************************
  mrs_tx_st_t  tx_st;
  logic        rx_on;
  logic        line_busy;
  logic [14:0] hb_cnt;
  logic [14:0] hb_max;
  logic        hb_tick;
  logic [7:0]  idle_hb;

  assign line_busy = rx_on | (tx_st == TX_SEND);
  assign hb_max    = 15'(baud_div[15:1] - 15'h1);
  assign hb_tick   = !line_busy && hb_cnt >= hb_max;

  always_ff @(posedge i_clk_sys) begin
    if (i_rst || line_busy || hb_cnt >= hb_max) begin
      hb_cnt <= 15'h0;
    end else begin
      hb_cnt <= hb_cnt + 15'h1;
    end
  end

  // Saturates well above the longest gap of 77 half-bits
  always_ff @(posedge i_clk_sys) begin
    if (i_rst || line_busy) begin
      idle_hb <= 8'h00;
    end else if (hb_tick && idle_hb != 8'hff) begin
      idle_hb <= idle_hb + 8'h01;
    end
  end

  // ************************************************************
  // Character receiver
  // ************************************************************
  logic        rx_en;
  logic [15:0] rx_clk;
  logic [3:0]  rx_bit;
  logic [10:0] rx_sh;
  logic        rx_done;
  logic        gap_long;
  logic [7:0]  rx_byte;
  logic [10:0] rx_exp;
  logic [3:0]  par_pos;
  logic [3:0]  last_pos;
  logic        rx_perr;
  logic        rx_ferr;

  // Own echo is not received while driving the line
  assign rx_en    = tx_st != TX_SEND;
  assign last_pos = 4'(nbits - (cfg_par == PAR_NONE ? 8'h2 : 8'h1));
  assign par_pos  = cfg_d8 ? 4'h9 : 4'h8;

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      rx_on    <= 1'b0;
      rx_clk   <= 16'h0;
      rx_bit   <= 4'h0;
      rx_sh    <= 11'h0;
      rx_done  <= 1'b0;
      gap_long <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      if (!rx_on) begin
        if (rx_en && !i_rxd) begin
          rx_on    <= 1'b1;
          rx_clk   <= {1'b0, baud_div[15:1]};
          rx_bit   <= 4'h0;
          gap_long <= idle_hb > t15;
        end
      end else if (rx_clk != 16'h0) begin
        rx_clk <= rx_clk - 16'h1;
      end else if (rx_bit == 4'h0 && i_rxd) begin
        // Start bit gone by mid-bit: a glitch, not a character
        rx_on <= 1'b0;
      end else begin
        rx_sh[rx_bit] <= i_rxd;
        rx_clk        <= baud_div - 16'h1;
        rx_bit        <= rx_bit + 4'h1;
        if (rx_bit == last_pos) begin
          rx_on   <= 1'b0;
          rx_done <= 1'b1;
        end
      end
    end
  end

  // Only data bits reach the CRC; framing bits stay behind
  assign rx_byte = cfg_d8 ? rx_sh[8:1] : {1'b0, rx_sh[7:1]};
  assign rx_exp  = char_frame(rx_byte, cfg_d8, cfg_par);
  assign rx_perr = cfg_par != PAR_NONE &&
                   rx_sh[par_pos] != rx_exp[par_pos];
  assign rx_ferr = !rx_sh[last_pos];

  // ************************************************************
  // Frame delimiting and checking
  // ************************************************************
  mrs_fr_st_t  fr_st;
  logic [7:0]  rx_buf [BUF_DEPTH];
  logic [5:0]  rx_len;
  logic [15:0] rx_crc;
  logic        rx_bad;
  logic        ev_ready;
  logic        ev_crc;
  logic        ev_len;
  logic        f_bcast;
  logic        f_read;
  logic        f_write;
  logic        f_other;
  logic [5:0]  f_len;
  logic        addr_hit;
  logic        len_bad;

  assign addr_hit = rx_buf[0] == cfg_addr || rx_buf[0] == ADDR_BCAST;
  assign len_bad  = rx_len > BUF_FULL || rx_len[0] ||
                    (rx_buf[1] == FUNC_READ &&
                     {rx_buf[4], rx_buf[5]} > MAX_READ_WORDS);

  always_ff @(posedge i_clk_sys) begin
    if (rx_done && fr_st != FR_WAIT) begin
      if (fr_st == FR_READY || gap_long) begin
        rx_buf[0] <= rx_byte;
      end else if (rx_len < BUF_FULL) begin
        rx_buf[rx_len[4:0]] <= rx_byte;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      fr_st    <= FR_WAIT;
      rx_len   <= 6'h0;
      rx_crc   <= CRC_INIT;
      rx_bad   <= 1'b0;
      ev_ready <= 1'b0;
      ev_crc   <= 1'b0;
      ev_len   <= 1'b0;
      f_bcast  <= 1'b0;
      f_read   <= 1'b0;
      f_write  <= 1'b0;
      f_other  <= 1'b0;
      f_len    <= 6'h0;
    end else begin
      ev_ready <= 1'b0;
      ev_crc   <= 1'b0;
      ev_len   <= 1'b0;
      case (fr_st)
        FR_WAIT: begin
          // After reset the line must first be seen quiet
          if (!rx_on && idle_hb >= t35) begin
            fr_st <= FR_READY;
          end
        end
        FR_READY: begin
          if (rx_done) begin
            fr_st  <= FR_BODY;
            rx_len <= 6'h1;
            rx_crc <= crc_byte(CRC_INIT, rx_byte);
            rx_bad <= rx_perr | rx_ferr;
          end
        end
        FR_BODY: begin
          if (rx_done && gap_long) begin
            rx_len <= 6'h1;
            rx_crc <= crc_byte(CRC_INIT, rx_byte);
            rx_bad <= rx_perr | rx_ferr;
          end else if (rx_done) begin
            // An inter-frame gap of at most t15 half-bits lands here and merges frames
            if (rx_len != 6'h3f) begin
              rx_len <= rx_len + 6'h1;
            end
            rx_crc <= crc_byte(rx_crc, rx_byte);
            rx_bad <= rx_bad | rx_perr | rx_ferr;
          end else if (!rx_on && idle_hb >= t35) begin
            fr_st <= FR_READY;
            if (rx_len < MIN_FRAME) begin
              ev_len <= 1'b1;
            end else if (rx_crc != 16'h0) begin
              ev_crc <= 1'b1;
            end else if (addr_hit && !rx_bad) begin
              ev_ready <= 1'b1;
              ev_len   <= len_bad;
              f_bcast  <= rx_buf[0] == ADDR_BCAST;
              f_read   <= rx_buf[1] == FUNC_READ;
              f_write  <= rx_buf[1] == FUNC_WRITE;
              f_other  <= rx_buf[1] != FUNC_READ &&
                          rx_buf[1] != FUNC_WRITE;
              f_len    <= rx_len;
            end
          end
        end
        default: begin
          fr_st <= FR_WAIT;
        end
      endcase
    end
  end

  // ************************************************************
  // Status flags
  // ************************************************************
  logic [3:0] stat;
  logic [3:0] stat_set;
  logic [3:0] stat_clr;
  logic       par_ev;

  assign par_ev   = rx_done && rx_perr && fr_st != FR_WAIT;
  assign stat_set = {ev_len, par_ev, ev_crc, ev_ready};
  assign stat_clr = (i_wr && i_addr == REG_STAT) ? i_wdata[3:0] : 4'h0;

  // A flag raised in the cycle it is cleared survives
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      stat <= 4'h0;
    end else begin
      stat <= (stat & ~stat_clr) | stat_set;
    end
  end

  // ************************************************************
  // Response transmitter
  // ************************************************************
  logic [7:0]  tx_buf [BUF_DEPTH];
  logic [5:0]  tx_cnt;
  logic [5:0]  tx_idx;
  logic [15:0] tx_crc;
  logic [10:0] tx_sh;
  logic [3:0]  tx_left;
  logic [15:0] tx_clk;
  logic [7:0]  tx_b;
  logic        tx_more;
  logic        tx_payload;
  logic [10:0] tx_frm;
  logic        tx_go;

  assign tx_go = i_wr && i_addr == REG_TXCTRL && i_wdata[TXC_GO] &&
                 tx_st == TX_IDLE && tx_cnt != 6'h0 &&
                 !f_bcast;

  // Software bytes first, then CRC low and high
  always_comb begin
    tx_payload = tx_idx < tx_cnt;
    tx_more    = tx_idx <= tx_cnt;
    if (tx_payload) begin
      tx_b = tx_buf[tx_idx[4:0]];
    end else if (tx_idx == tx_cnt) begin
      tx_b = tx_crc[7:0];
    end else begin
      tx_b = tx_crc[15:8];
    end
    if (!cfg_d8) begin
      tx_b[7] = 1'b0;
    end
  end
  assign tx_frm = char_frame(tx_b, cfg_d8, cfg_par);

  always_ff @(posedge i_clk_sys) begin
    if (i_wr && i_addr == REG_TXDATA && tx_st == TX_IDLE &&
        tx_cnt < BUF_FULL) begin
      tx_buf[tx_cnt[4:0]] <= i_wdata[7:0];
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      tx_cnt <= 6'h0;
    end else if (tx_st == TX_IDLE && i_wr && i_addr == REG_TXCTRL &&
                 i_wdata[TXC_CLR]) begin
      tx_cnt <= 6'h0;
    end else if (tx_st == TX_IDLE && i_wr && i_addr == REG_TXDATA &&
                 tx_cnt < BUF_FULL) begin
      tx_cnt <= tx_cnt + 6'h1;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      tx_st   <= TX_IDLE;
      tx_idx  <= 6'h0;
      tx_crc  <= CRC_INIT;
      tx_sh   <= 11'h7ff;
      tx_left <= 4'h0;
      tx_clk  <= 16'h0;
      o_txd   <= 1'b1;
      o_de    <= 1'b0;
    end else begin
      case (tx_st)
        TX_IDLE: begin
          if (tx_go) begin
            tx_st  <= TX_WAIT;
            tx_idx <= 6'h0;
            tx_crc <= CRC_INIT;
          end
        end
        TX_WAIT: begin
          if (!rx_on && idle_hb >= t35) begin
            tx_st   <= TX_SEND;
            o_de    <= 1'b1;
            o_txd   <= tx_frm[0];
            tx_sh   <= tx_frm;
            tx_left <= nbits[3:0];
            tx_clk  <= baud_div - 16'h1;
            tx_idx  <= tx_idx + 6'h1;
            tx_crc  <= crc_byte(tx_crc, tx_b);
          end
        end
        TX_SEND: begin
          if (tx_clk != 16'h0) begin
            tx_clk <= tx_clk - 16'h1;
          end else if (tx_left != 4'h1) begin
            tx_sh   <= {1'b1, tx_sh[10:1]};
            o_txd   <= tx_sh[1];
            tx_left <= tx_left - 4'h1;
            tx_clk  <= baud_div - 16'h1;
          end else if (tx_more || tx_idx == tx_cnt + 6'h1) begin
            o_txd   <= tx_frm[0];
            tx_sh   <= tx_frm;
            tx_left <= nbits[3:0];
            tx_clk  <= baud_div - 16'h1;
            tx_idx  <= tx_idx + 6'h1;
            if (tx_payload) begin
              tx_crc <= crc_byte(tx_crc, tx_b);
            end
          end else begin
            // Release only after the last stop bit has been held
            tx_st <= TX_IDLE;
            o_de  <= 1'b0;
            o_txd <= 1'b1;
          end
        end
        default: begin
          tx_st <= TX_IDLE;
          o_de  <= 1'b0;
          o_txd <= 1'b1;
        end
      endcase
    end
  end

  // ************************************************************
  // Register read port
  // ************************************************************
  always_ff @(posedge i_clk_sys) begin
    if (i_rst || !i_rd) begin
      o_rdata <= 32'h0;
    end else if (i_addr == REG_CTRL) begin
      o_rdata <= {16'h0, ctrl};
    end else if (i_addr == REG_BAUD) begin
      o_rdata <= {16'h0, baud_div};
    end else if (i_addr == REG_STAT) begin
      o_rdata <= {10'h0, f_len, 7'h0, tx_st != TX_IDLE,
                  f_other, f_write, f_read, f_bcast, stat};
    end else if (i_addr == REG_TXCTRL) begin
      o_rdata <= {26'h0, tx_cnt};
    end else if (i_addr[7]) begin
      o_rdata <= {24'h0, rx_buf[i_addr[6:2]]};
    end else begin
      o_rdata <= 32'h0;
    end
  end

endmodule // mrs_framer

// File: mrs_framer_props.sv
// Purpose: Port checks of the RTU slave framer.
// Assumes: Settings reach the block only through the register port.
// Notes:   stop_high_a needs a divisor of 8 or more.
`timescale 1ns/1ps
module mrs_framer_props
  import mrs_pkg::*;
(
  input wire logic        i_clk_sys,
  input wire logic        i_rst,
  input wire logic [7:0]  i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic        i_rxd,
  input wire logic        o_txd,
  input wire logic        o_de
);
  // ********
  // Shadow settings and counters
  // ********
  logic [15:0] baud;
  logic        data8;
  int          de_cnt;
  int          idle_cnt;
  int          char_clk;

  assign char_clk = (data8 ? 11 : 10) * int'(baud);

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      baud  <= BAUD_DIV_RST;
      data8 <= CTRL_RST[CTRL_DATA8];
    end else if (i_wr && i_addr == REG_BAUD) begin
      baud <= i_wdata[15:0];
    end else if (i_wr && i_addr == REG_CTRL) begin
      data8 <= i_wdata[CTRL_DATA8];
    end
  end

  always_ff @(posedge i_clk_sys) begin
    de_cnt <= (i_rst || !o_de) ? 0 : de_cnt + 1;
  end

  // Idle only while the driver is off and the line is high
  always_ff @(posedge i_clk_sys) begin
    if (i_rst || o_de || !i_rxd) begin
      idle_cnt <= 0;
    end else if (idle_cnt < 1_000_000) begin
      idle_cnt <= idle_cnt + 1;
    end
  end

  // ********
  // Properties
  // ********
  line_idle_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    !o_de |-> o_txd) else $error("line low with driver off");
  reset_quiet_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    $fell(i_rst) |-> !o_de && o_txd && o_rdata == 32'h0)
    else $error("outputs not idle after reset");
  start_low_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    o_de && de_cnt < int'(baud) |-> !o_txd) else $error("start bit short");
  bit_edge_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    o_de && $changed(o_txd) |-> de_cnt % int'(baud) == 0)
    else $error("txd moved inside a bit");
  stop_high_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    $fell(o_de) |-> $past(o_txd, 1) && $past(o_txd, 8))
    else $error("last stop bit not high");
  char_len_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    $fell(o_de) |-> de_cnt > 0 && de_cnt % char_clk < 2)
    else $error("reply not whole characters");
  gap_tx_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    $rose(o_de) |-> $past(idle_cnt) >= 7 * char_clk / 2)
    else $error("reply started without idle gap");
  rdata_quiet_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    !$past(i_rd) |-> o_rdata == 32'h0) else $error("read data off cycle");
endmodule // mrs_framer_props

bind mrs_framer mrs_framer_props u_props (
  .i_clk_sys (i_clk_sys),
  .i_rst     (i_rst),
  .i_addr    (i_addr),
  .i_wdata   (i_wdata),
  .i_wr      (i_wr),
  .i_rd      (i_rd),
  .o_rdata   (o_rdata),
  .i_rxd     (i_rxd),
  .o_txd     (o_txd),
  .o_de      (o_de)
);

// File: mrs_master.sv
// Purpose: Bus master model on the far side of the RTU framer.
// Assumes: Same divisor, data width and parity as the slave.
// Notes:   Reply capture handles 8 data bits without parity only.
`timescale 1ns/1ps
module mrs_master
  import mrs_pkg::*;
(
  input  wire logic        i_clk_sys,
  input  wire logic [15:0] i_baud,
  input  wire logic        i_data8,
  input  wire logic [1:0]  i_par,
  input  wire logic        i_txd,
  input  wire logic        i_de,
  output logic             o_line
);
  logic [7:0] rx_q[$];

  // Bias resistors hold the released line high
  initial o_line = 1'b1;

  task automatic put(input logic v);
    o_line <= v;
    repeat (i_baud) @(posedge i_clk_sys);
  endtask

  // Call right after a clock edge; ends on one
  task automatic send_byte(input logic [7:0] b, input logic flip);
    logic [7:0] d;
    d = i_data8 ? b : {1'b0, b[6:0]};
    put(1'b0);
    for (int i = 0; i < (i_data8 ? 8 : 7); i++) begin
      put(d[i]);
    end
    if (i_par != PAR_NONE) begin
      put((^d) ^ (i_par == PAR_ODD) ^ flip);
    end else begin
      put(1'b1);
    end
    put(1'b1);
  endtask

  initial begin
    logic [7:0] b;
    forever begin
      @(posedge i_clk_sys);
      if (i_de && !i_txd) begin
        repeat (i_baud / 2) @(posedge i_clk_sys);
        for (int i = 0; i < 8; i++) begin
          repeat (i_baud) @(posedge i_clk_sys);
          b[i] = i_txd;
        end
        rx_q.push_back(b);
        repeat (i_baud) @(posedge i_clk_sys);
      end
    end
  end
endmodule // mrs_master

// File: tb.sv
// Purpose: Self-checking bench of the RTU slave framer.
// Assumes: Divisor 8, so an 11-bit character lasts 88 clocks.
// Notes:   Status is compared with a queue model of the receiver.
`timescale 1ns/1ps
module tb
  import mrs_pkg::*;
;
  typedef logic [7:0] mrs_bq_t[$];
  localparam logic [31:0] MFULL = 32'h003f00ff;
  localparam logic [31:0] MERR  = 32'h0000000f;
  logic        i_clk_sys;
  logic        i_rst;
  logic [7:0]  i_addr;
  logic [31:0] i_wdata;
  logic        i_wr;
  logic        i_rd;
  logic [31:0] o_rdata;
  logic        o_txd;
  logic        o_de;
  logic        line;
  logic [15:0] baud;
  logic        data8;
  logic [1:0]  par;
  logic [7:0]  own;
  int          fail_count;
  int          samples_checked;

  mrs_framer dut (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_addr    (i_addr),
    .i_wdata   (i_wdata),
    .i_wr      (i_wr),
    .i_rd      (i_rd),
    .o_rdata   (o_rdata),
    .i_rxd     (line),
    .o_txd     (o_txd),
    .o_de      (o_de)
  );
  mrs_master pm (
    .i_clk_sys (i_clk_sys),
    .i_baud    (baud),
    .i_data8   (data8),
    .i_par     (par),
    .i_txd     (o_txd),
    .i_de      (o_de),
    .o_line    (line)
  );

  initial begin
    i_clk_sys = 1'b0;
    forever #2 i_clk_sys = ~i_clk_sys;
  end

  // ********
  // Model and checking
  // ********
  function automatic logic [15:0] crc16(input mrs_bq_t q);
    logic [15:0] c;
    c = CRC_INIT;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      for (int k = 0; k < 8; k++) begin
        c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
      end
    end
    return c;
  endfunction

  function automatic mrs_bq_t mk(input logic [7:0] a, input logic [7:0] f,
                                 input logic [15:0] w1, input logic [15:0] w2);
    mrs_bq_t q;
    logic [15:0] c;
    q = {a, f, w1[15:8], w1[7:0], w2[15:8], w2[7:0]};
    c = crc16(q);
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    return q;
  endfunction

  function automatic logic [31:0] model_st(input mrs_bq_t q);
    logic [31:0] s;
    int n;
    s = 32'h0;
    n = q.size();
    if (n < 6) begin
      s[ST_LEN] = 1'b1;
    end else if (crc16(q) != 16'h0) begin
      s[ST_CRC] = 1'b1;
    end else if (q[0] == own || q[0] == ADDR_BCAST) begin
      s[ST_READY] = 1'b1;
      s[ST_BCAST] = (q[0] == ADDR_BCAST);
      s[ST_FRD] = (q[1] == FUNC_READ);
      s[ST_FWR] = (q[1] == FUNC_WRITE);
      s[ST_FOTH] = !(s[ST_FRD] || s[ST_FWR]);
      s[ST_LEN] = n > 32 || n % 2 == 1 ||
                  (s[ST_FRD] && {q[4], q[5]} > MAX_READ_WORDS);
      s[21:16] = 6'(n);
    end
    return s;
  endfunction

  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk_sys);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_clk_sys);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask

  task automatic cfg(input logic [1:0] p);
    par = p;
    wr(REG_CTRL, {16'h0, own, 5'h0, p, data8});
  endtask

  // Sends a frame, optionally a bad parity bit or a pause before one byte
  task automatic frame_chk(input mrs_bq_t q, input int flip, input int gap_at,
                           input int gap, input logic [31:0] mask,
                           input logic [31:0] exp);
    logic [31:0] st;
    wr(REG_STAT, MERR);
    @(posedge i_clk_sys);
    foreach (q[i]) begin
      if (i == gap_at) repeat (gap) @(posedge i_clk_sys);
      pm.send_byte(q[i], i == flip);
    end
    repeat (440) @(posedge i_clk_sys);
    rd(REG_STAT, st);
    check("status", st & mask, exp & mask);
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    repeat (90000) @(posedge i_clk_sys);
    fail_count++;
    report_and_stop();
  end

  // ********
  // Scenarios
  // ********
  initial begin
    logic [31:0] d;
    logic [15:0] w;
    mrs_bq_t q;
    mrs_bq_t q2;
    int k;
    i_rst = 1'b1;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 8'h00;
    i_wdata = 32'h0;
    fail_count = 0;
    samples_checked = 0;
    baud = BAUD_DIV_RST;
    data8 = 1'b1;
    par = PAR_NONE;
    own = 8'h01;
    void'($urandom(46280));
    repeat (16) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    rd(REG_CTRL, d);
    check("ctrl reset", d, {16'h0, CTRL_RST});
    rd(8'h0c, d);
    check("unmapped", d, 32'h0);
    baud = 16'h0008;
    wr(REG_BAUD, {16'h0, baud});
    own = 8'($urandom_range(1, 246));
    cfg(PAR_NONE);
    repeat (600) @(posedge i_clk_sys);
    w = 16'($urandom_range(1, 16));
    q = mk(own, FUNC_READ, 16'($urandom), w);
    frame_chk(q, -1, -1, 0, MFULL, model_st(q));
    for (int i = 0; i < 8; i++) begin
      rd(REG_RXBUF + 8'(4 * i), d);
      check("rx byte", d, {24'h0, q[i]});
    end
    pm.rx_q.delete();
    q2 = {};
    for (int i = 0; i < 4; i++) begin
      q2.push_back(8'($urandom));
      wr(REG_TXDATA, {24'h0, q2[i]});
    end
    wr(REG_TXCTRL, 32'h1);
    d = 32'h100;
    k = 0;
    while (d[ST_BUSY] !== 1'b0 && k < 200) begin
      repeat (20) @(posedge i_clk_sys);
      rd(REG_STAT, d);
      k++;
    end
    w = crc16(q2);
    q2.push_back(w[7:0]);
    q2.push_back(w[15:8]);
    check("tx count", pm.rx_q.size(), q2.size());
    foreach (q2[i]) check("tx byte", pm.rx_q[i], q2[i]);
    wr(REG_TXCTRL, 32'h2);
    q = mk(own, FUNC_WRITE, 16'($urandom), 16'($urandom));
    frame_chk(q, -1, -1, 0, MFULL, model_st(q));
    q = mk(own, 8'h08, 16'h0, 16'($urandom));
    frame_chk(q, -1, -1, 0, MFULL, model_st(q));
    q[6] = q[6] ^ 8'h01;
    frame_chk(q, -1, -1, 0, MERR, model_st(q));
    q = {own, FUNC_READ, 8'h00, 8'h01};
    frame_chk(q, -1, -1, 0, MERR, model_st(q));
    q = mk(own, FUNC_READ, 16'h0, MAX_READ_WORDS + 16'h1);
    frame_chk(q, -1, -1, 0, 32'h8, model_st(q));
    q = mk(own + 8'h01, FUNC_READ, 16'h0, 16'h1);
    frame_chk(q, -1, -1, 0, MERR, model_st(q));
    q2 = mk(own, FUNC_WRITE, 16'($urandom), 16'($urandom));
    q = {8'($urandom), 8'($urandom), 8'($urandom)};
    frame_chk({q, q2}, -1, 3, 176, MFULL, model_st(q2));
    q = {q2, mk(own, FUNC_READ, 16'h0, 16'h2)};
    frame_chk(q, -1, 8, 44, MERR, model_st(q));
    for (int p = 1; p <= 2; p++) begin
      cfg(2'(p));
      q = mk(own, FUNC_READ, 16'($urandom), 16'h1);
      frame_chk(q, -1, -1, 0, MFULL, model_st(q));
      frame_chk(q, 2, -1, 0, MERR, 32'h4);
    end
    cfg(PAR_NONE);
    q = mk(ADDR_BCAST, FUNC_WRITE, 16'($urandom), 16'($urandom));
    frame_chk(q, -1, -1, 0, MFULL, model_st(q));
    pm.rx_q.delete();
    wr(REG_TXDATA, 32'h5a);
    wr(REG_TXCTRL, 32'h1);
    repeat (1500) @(posedge i_clk_sys);
    check("bcast reply", pm.rx_q.size(), 0);
    wr(REG_TXCTRL, 32'h2);
    data8 = 1'b0;
    cfg(PAR_EVEN);
    foreach (q[i]) q[i] = q[i] & 8'h7f;
    frame_chk(q, -1, -1, 0, MERR, model_st(q));
    report_and_stop();
  end
endmodule // tb
